/* tos_defines.vh */
`ifndef TOS_DEFINES_VH
`define TOS_DEFINES_VH
// Heat rise fixed point: 1.0 (100 %) = 2^16
`define TOS_HEAT_W          24
`define TOS_HEAT_FRAC       16
`define TOS_PCT_SCALE       7'h64
// Currents are Q8.8 multiples of base_current
`define TOS_CUR_W           16
`define TOS_RUN_THRESHOLD   16'h0019
// Setting ranges
`define TOS_SETPOINT_MIN    9'h032
`define TOS_SETPOINT_MAX    9'h12c
`define TOS_OFFSET_MAX      9'h064
`define TOS_HEAT_TC_MIN     10'h001
`define TOS_HEAT_TC_MAX     10'h078
`define TOS_COOL_TC_MIN     10'h005
`define TOS_COOL_TC_MAX     10'h258
`define TOS_TMAX_MIN        8'h3c
`define TOS_TMAX_MAX        8'hc8
`define TOS_AMBIENT_REF     8'h28
`define TOS_SWITCH_MIN      16'h0040
`define TOS_SWITCH_MAX      16'h0800
// Negative-sequence factor in quarters: 0, 2.25, 4.5, 9
`define TOS_K_CODE_0        6'h00
`define TOS_K_CODE_1        6'h09
`define TOS_K_CODE_2        6'h12
`define TOS_K_CODE_3        6'h24
// Setting bank field indices
`define TOS_FLD_ALARM       3'h0
`define TOS_FLD_TRIP        3'h1
`define TOS_FLD_OFFSET      3'h2
`define TOS_FLD_HEAT_TC     3'h3
`define TOS_FLD_COOL_TC     3'h4
// Timing: one heat step is 1/1024 of a time constant
`define TOS_CLK_HZ          64'd40000000
`define TOS_MINUTE_S        64'd60
`define TOS_STEP_SHIFT      10
`define TOS_PRED_MAX_STEPS  14'h3fff
`endif

/* tos_group_bank.v */
`timescale 1ns/10ps
`default_nettype none
`include "tos_defines.vh"
module tos_group_bank
(
    input  wire        clk,
    input  wire        reset,
    input  wire        write_en,
    input  wire        write_group,
    input  wire [2:0]  write_field,
    input  wire [15:0] write_data,
    input  wire        read_group,
    output reg  [8:0]  alarm_pct,
    output reg  [8:0]  trip_pct,
    output reg  [8:0]  offset_pct,
    output reg  [9:0]  heat_tc,
    output reg  [9:0]  cool_tc
);
    reg [15:0] mem [0:15];
    wire [3:0] row = {read_group, 3'h0};
    integer i;

    always @(posedge clk)
    begin
        if (reset)
        begin
            for (i = 0; i < 16; i = i + 1)
                mem[i] <= 16'h0000;
        end
        else if (write_en)
            mem[{write_group, write_field}] <= write_data;
    end

    // Registered read of the five setting fields (0 to 4) of the active row
    always @(posedge clk)
    begin
        if (reset)
        begin
            alarm_pct  <= `TOS_SETPOINT_MAX;
            trip_pct   <= `TOS_SETPOINT_MAX;
            offset_pct <= 9'h000;
            heat_tc    <= `TOS_HEAT_TC_MAX;
            cool_tc    <= `TOS_COOL_TC_MAX;
        end
        else
        begin
            alarm_pct  <= mem[row | {1'b0, `TOS_FLD_ALARM}][8:0];
            trip_pct   <= mem[row | {1'b0, `TOS_FLD_TRIP}][8:0];
            offset_pct <= mem[row | {1'b0, `TOS_FLD_OFFSET}][8:0];
            heat_tc    <= mem[row | {1'b0, `TOS_FLD_HEAT_TC}][9:0];
            cool_tc    <= mem[row | {1'b0, `TOS_FLD_COOL_TC}][9:0];
        end
    end
endmodule // tos_group_bank
`default_nettype wire

/* tos_remote_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tos_remote_model
(
    input  wire logic clk,
    input  wire logic send_inhibit,
    input  wire logic send_enable,
    input  wire logic close_request,
    input  wire logic start_inhibit,
    output var logic  remote_thermal_inhibit_order,
    output var logic  remote_thermal_enable_order,
    output var logic  breaker_closed
);
    // Orders repeat the send requests one cycle later and last as long as each request
    always @(posedge clk)
    begin
        remote_thermal_inhibit_order <= send_inhibit;
        remote_thermal_enable_order <= send_enable;
        breaker_closed <= close_request && !start_inhibit;
    end
endmodule // tos_remote_model
`default_nettype wire

/* tos_supervisor.v */
// Function
// - Block motor closing while heat rise exceeds the restart-permitting level.
// - One start-inhibit output merges thermal and starts-per-hour blocking.
// - Lockout input or remote inhibit order suppresses motor thermal tripping.
// - Remote enable order restores thermal tripping.
// - Transformer use: group-select input picks natural or forced cooling group.
// - Group change keeps accumulated heat rise, continues with new parameters.
// - Motor use: second group when input set or current exceeds threshold.
// - Report time to restart, time to trip and present heat rise.
// - Initial heat rise 0 to 100 percent per group.
// - Heating time constant 1 to 120 minutes per group.
// - Cooling time constant 5 to 600 minutes per group.
// - Maximum temperature 60 to 200 C, used for ambient correction.
// - Initial heat rise shortens cold trips only, hot trips unchanged.
// - Unset second-group parameters have no effect by default.
// - Trip above trip set point, alarm above alarm set point.
// - Running above 0.1 base current uses heating constant, else cooling.
// - Negative-sequence factor limited to 0, 2.25, 4.5, 9.
// - Save heat plus ten percent on trip; clear at restart; reuse after power loss.
`timescale 1ns/10ps
`default_nettype none
`include "tos_defines.vh"
module tos_supervisor
#(
    parameter BASE_TICK_CYCLES = 2343750
)
(
    input  wire        clk,
    input  wire        reset,
    input  wire        motor_mode,
    input  wire [15:0] phase_current,
    input  wire [15:0] negseq_current,
    input  wire [1:0]  negseq_factor_sel,
    input  wire [7:0]  ambient_temp,
    input  wire        ambient_valid,
    input  wire [7:0]  max_equipment_temp,
    input  wire [15:0] group_switch_current_threshold,
    input  wire        group_b_configured,
    input  wire [8:0]  start_heat_allowance,
    input  wire        setting_write,
    input  wire        setting_group,
    input  wire [2:0]  setting_field,
    input  wire [15:0] setting_data,
    input  wire        group_select_input,
    input  wire        thermal_lockout_input,
    input  wire        remote_thermal_inhibit_order,
    input  wire        remote_thermal_enable_order,
    input  wire        starts_per_hour_inhibit,
    input  wire [23:0] restore_heat,
    input  wire        restore_valid,
    output reg         thermal_alarm,
    output reg         thermal_trip,
    output reg         start_inhibit,
    output reg  [23:0] heat_rise,
    output reg  [23:0] saved_heat,
    output reg  [15:0] time_to_trip,
    output reg  [15:0] time_to_restart,
    output reg         active_group
);
    localparam P_IDLE = 2'b00;
    localparam P_TRIP = 2'b01;
    localparam P_REST = 2'b10;

    // Pin synchronisers
    reg  [1:0] sel_sync;
    reg  [1:0] lock_sync;
    always @(posedge clk)
    begin
        sel_sync  <= {sel_sync[0], group_select_input};
        lock_sync <= {lock_sync[0], thermal_lockout_input};
    end

    // Setting write with range clamping
    reg [15:0] wr_data;
    always @*
    begin
        wr_data = setting_data;
        case (setting_field)
            `TOS_FLD_ALARM, `TOS_FLD_TRIP:
                if (setting_data < {7'h00, `TOS_SETPOINT_MIN}) wr_data = {7'h00, `TOS_SETPOINT_MIN};
                else if (setting_data > {7'h00, `TOS_SETPOINT_MAX}) wr_data = {7'h00, `TOS_SETPOINT_MAX};
            `TOS_FLD_OFFSET:
                if (setting_data > {7'h00, `TOS_OFFSET_MAX}) wr_data = {7'h00, `TOS_OFFSET_MAX};
            `TOS_FLD_HEAT_TC:
                if (setting_data < {6'h00, `TOS_HEAT_TC_MIN}) wr_data = {6'h00, `TOS_HEAT_TC_MIN};
                else if (setting_data > {6'h00, `TOS_HEAT_TC_MAX}) wr_data = {6'h00, `TOS_HEAT_TC_MAX};
            `TOS_FLD_COOL_TC:
                if (setting_data < {6'h00, `TOS_COOL_TC_MIN}) wr_data = {6'h00, `TOS_COOL_TC_MIN};
                else if (setting_data > {6'h00, `TOS_COOL_TC_MAX}) wr_data = {6'h00, `TOS_COOL_TC_MAX};
            default:
                wr_data = setting_data;
        endcase
    end

    wire [8:0] alarm_heat_setpoint;
    wire [8:0] trip_heat_setpoint;
    wire [8:0] initial_heat_offset;
    wire [9:0] heating_time_constant;
    wire [9:0] cooling_time_constant;

    tos_group_bank tos_group_bank_inst
    (
        .clk         (clk),
        .reset       (reset),
        .write_en    (setting_write),
        .write_group (setting_group),
        .write_field (setting_field),
        .write_data  (wr_data),
        .read_group  (active_group),
        .alarm_pct   (alarm_heat_setpoint),
        .trip_pct    (trip_heat_setpoint),
        .offset_pct  (initial_heat_offset),
        .heat_tc     (heating_time_constant),
        .cool_tc     (cooling_time_constant)
    );

    // Squared equivalent current with negative-sequence weighting
    reg  [5:0]  k_quarters;
    always @*
    begin
        case (negseq_factor_sel)
            2'h0:    k_quarters = `TOS_K_CODE_0;
            2'h1:    k_quarters = `TOS_K_CODE_1;
            2'h2:    k_quarters = `TOS_K_CODE_2;
            default: k_quarters = `TOS_K_CODE_3;
        endcase
    end
    wire [31:0] iph_sq = phase_current * phase_current;
    wire [31:0] ii_sq  = negseq_current * negseq_current;
    wire [37:0] ii_wt  = ii_sq * k_quarters;
    wire [38:0] eq_sum = {7'h00, iph_sq} + {3'h0, ii_wt[37:2]};
    wire [23:0] target = (|eq_sum[38:24]) ? 24'hffffff : eq_sum[23:0];
    wire [31:0] sw_sq  = group_switch_current_threshold * group_switch_current_threshold;
    wire        running = phase_current > `TOS_RUN_THRESHOLD;

    // Group select; an unconfigured second group is never used
    wire want_b = motor_mode ? (sel_sync[1] | ({8'h00, target} > sw_sq))
                             : sel_sync[1];
    always @(posedge clk)
    begin
        if (reset)
            active_group <= 1'b0;
        else
            active_group <= want_b & group_b_configured;
    end

    // Ambient correction as cross-multiplied compare, avoids a divider
    wire [7:0] tmax   = (max_equipment_temp < `TOS_TMAX_MIN) ? `TOS_TMAX_MIN :
                        (max_equipment_temp > `TOS_TMAX_MAX) ? `TOS_TMAX_MAX : max_equipment_temp;
    wire       amb_hot = ambient_valid && (ambient_temp > `TOS_AMBIENT_REF);
    wire [7:0] corr_num = tmax - `TOS_AMBIENT_REF;
    wire [7:0] corr_den = !amb_hot ? corr_num :
                          (ambient_temp >= tmax) ? 8'h01 : tmax - ambient_temp;

    function heat_over;
        input [23:0] heat;
        input [8:0]  pct;
        input [7:0]  num;
        input [7:0]  den;
        reg   [46:0] lhs;
        reg   [46:0] rhs;
        begin
            lhs = heat * `TOS_PCT_SCALE * num;
            rhs = {pct, 16'h0000} * den;
            heat_over = lhs > rhs;
        end
    endfunction

    function [23:0] pct_to_heat;
        input [8:0] pct;
        reg   [31:0] scaled;
        begin
            scaled = {pct, 16'h0000} / `TOS_PCT_SCALE;
            pct_to_heat = scaled[23:0];
        end
    endfunction

    function [23:0] heat_step;
        input [23:0] heat;
        input [23:0] tgt;
        reg   [24:0] diff;
        begin
            diff = {1'b0, tgt} - {1'b0, heat};
            heat_step = heat + {{9{diff[24]}}, diff[24:10]};
            if (diff != 25'h0 && diff[24:10] == 15'h0)
                heat_step = heat + 24'h000001;
            else if (diff != 25'h0 && diff[24:10] == 15'h7fff && heat != 24'h0)
                heat_step = heat - 24'h000001;
        end
    endfunction

    wire [8:0] restart_pct = (trip_heat_setpoint > start_heat_allowance) ?
                             trip_heat_setpoint - start_heat_allowance : 9'h000;
    wire [23:0] offset_heat = pct_to_heat(initial_heat_offset);

    // Heat step timing: base tick is 1/1024 minute, steps every tc base ticks
    reg  [31:0] base_cnt;
    reg  [9:0]  tc_cnt;
    reg         init_pending;
    wire        base_tick = base_cnt == BASE_TICK_CYCLES - 1;
    wire [9:0]  tc_now = running ? heating_time_constant : cooling_time_constant;
    wire        heat_tick = base_tick && (tc_cnt >= tc_now - 10'h001);
    wire [23:0] stepped = heat_step(heat_rise, running ? target : 24'h000000);
    wire        trip_now = heat_over(heat_rise, trip_heat_setpoint, corr_num, corr_den);
    wire        thermal_block = heat_over(heat_rise, restart_pct, corr_num, corr_den);
    reg         lockout;

    always @(posedge clk)
    begin
        if (reset)
        begin
            base_cnt      <= 32'h0;
            tc_cnt        <= 10'h000;
            init_pending  <= 1'b1;
            heat_rise     <= 24'h000000;
            saved_heat    <= 24'h000000;
            lockout       <= 1'b0;
            thermal_alarm <= 1'b0;
            thermal_trip  <= 1'b0;
            start_inhibit <= 1'b0;
        end
        else
        begin
            base_cnt <= base_tick ? 32'h0 : base_cnt + 32'h1;
            if (heat_tick)
                tc_cnt <= 10'h000;
            else if (base_tick)
                tc_cnt <= tc_cnt + 10'h001;
            // Power-up load: saved value wins over the cold offset
            if (init_pending)
            begin
                init_pending <= 1'b0;
                heat_rise    <= restore_valid ? restore_heat : offset_heat;
                saved_heat   <= restore_valid ? restore_heat : 24'h000000;
            end
            else if (heat_tick)
            begin
                // Floor at the offset only shortens cold trips; hot state is above it
                if (running && stepped < offset_heat)
                    heat_rise <= offset_heat;
                else
                    heat_rise <= stepped;
            end
            if (remote_thermal_inhibit_order)
                lockout <= 1'b1;
            else if (remote_thermal_enable_order)
                lockout <= 1'b0;
            thermal_alarm <= heat_over(heat_rise, alarm_heat_setpoint, corr_num, corr_den);
            thermal_trip  <= trip_now && !(motor_mode && (lockout || lock_sync[1]));
            start_inhibit <= (motor_mode && thermal_block) || starts_per_hour_inhibit;
            if (!init_pending)
            begin
                if (trip_now && !(motor_mode && (lockout || lock_sync[1])) && !thermal_trip)
                    saved_heat <= heat_rise + {4'h0, heat_rise[23:4]} + {5'h00, heat_rise[23:5]}
                                  + {8'h00, heat_rise[23:8]} + {9'h000, heat_rise[23:9]};
                else if (!thermal_block)
                    saved_heat <= 24'h000000;
            end
        end
    end

    // Forward predictor, one model step per clock, started on the first heat step after the previous pass has ended
    reg  [1:0]  pstate;
    reg  [23:0] p_heat;
    reg  [13:0] p_steps;
    wire [33:0] trip_sec = p_steps * heating_time_constant * 6'h3c;
    wire [33:0] rest_sec = p_steps * cooling_time_constant * 6'h3c;
    always @(posedge clk)
    begin
        if (reset)
        begin
            pstate          <= P_IDLE;
            p_heat          <= 24'h000000;
            p_steps         <= 14'h0000;
            time_to_trip    <= 16'hffff;
            time_to_restart <= 16'h0000;
        end
        else
        begin
            case (pstate)
                P_IDLE:
                    if (heat_tick)
                    begin
                        pstate  <= P_TRIP;
                        p_heat  <= heat_rise;
                        p_steps <= 14'h0000;
                    end
                P_TRIP:
                    if (heat_over(p_heat, trip_heat_setpoint, corr_num, corr_den) || p_steps == `TOS_PRED_MAX_STEPS)
                    begin
                        time_to_trip <= (p_steps == `TOS_PRED_MAX_STEPS || |trip_sec[33:26]) ? 16'hffff
                                        : trip_sec[25:10];
                        pstate       <= P_REST;
                        p_heat       <= heat_rise;
                        p_steps      <= 14'h0000;
                    end
                    else
                    begin
                        p_heat  <= heat_step(p_heat, target);
                        p_steps <= p_steps + 14'h0001;
                    end
                P_REST:
                    if (!heat_over(p_heat, restart_pct, corr_num, corr_den) || p_steps == `TOS_PRED_MAX_STEPS)
                    begin
                        time_to_restart <= (|rest_sec[33:26]) ? 16'hffff : rest_sec[25:10];
                        pstate          <= P_IDLE;
                    end
                    else
                    begin
                        p_heat  <= heat_step(p_heat, 24'h000000);
                        p_steps <= p_steps + 14'h0001;
                    end
                default:
                    pstate <= P_IDLE;
            endcase
        end
    end
endmodule // tos_supervisor
`default_nettype wire

/* tos_supervisor_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module tos_supervisor_assertions
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        motor_mode,
    input wire logic [15:0] phase_current,
    input wire logic [15:0] group_switch_current_threshold,
    input wire logic        group_b_configured,
    input wire logic        group_select_input,
    input wire logic        thermal_lockout_input,
    input wire logic        remote_thermal_inhibit_order,
    input wire logic        starts_per_hour_inhibit,
    input wire logic        ambient_valid,
    input wire logic        thermal_alarm,
    input wire logic        thermal_trip,
    input wire logic        start_inhibit,
    input wire logic [23:0] heat_rise,
    input wire logic [23:0] saved_heat,
    input wire logic        active_group
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_order_lockout: assert property (motor_mode && remote_thermal_inhibit_order |-> ##2 !thermal_trip)
        else $error("trip not held off by inhibit order");
    // Pin passes a two-stage synchroniser first
    a_input_lockout: assert property ((motor_mode && thermal_lockout_input) [*5] |-> !thermal_trip)
        else $error("trip not held off by lockout input");
    a_merge_inhibit: assert property (starts_per_hour_inhibit ##1 starts_per_hour_inhibit |-> start_inhibit)
        else $error("starts block not merged");
    a_xfmr_inhibit: assert property (!motor_mode && !starts_per_hour_inhibit |=> !start_inhibit)
        else $error("transformer start block without cause");
    a_xfmr_group_b: assert property ((!motor_mode && group_b_configured && group_select_input) [*6] |-> active_group)
        else $error("transformer group b not taken");
    a_xfmr_group_a: assert property ((!motor_mode && !group_select_input) [*6] |-> !active_group)
        else $error("transformer group a not taken");
    a_current_group: assert property ((motor_mode && group_b_configured
        && phase_current > group_switch_current_threshold) [*6] |-> active_group)
        else $error("current above threshold did not select group b");
    a_no_group_b: assert property (!group_b_configured [*2] |-> !active_group)
        else $error("unset group b selected");
    a_heat_kept: assert property ($changed(active_group) |-> heat_rise >= ($past(heat_rise) >> 1))
        else $error("heat lost on group change");
    // Set points cannot go below 50 percent
    a_trip_level: assert property (thermal_trip && !ambient_valid |-> $past(heat_rise) > 24'h008000)
        else $error("trip below lowest set point");
    a_alarm_level: assert property (thermal_alarm && !ambient_valid |-> $past(heat_rise) > 24'h008000)
        else $error("alarm below lowest set point");
    a_save_on_trip: assert property ($rose(thermal_trip) |-> ##[0:2] saved_heat > heat_rise)
        else $error("heat not saved with margin on trip");
endmodule // tos_supervisor_assertions

bind tos_supervisor tos_supervisor_assertions tos_supervisor_assertions_inst
(
    .clk(clk), .reset(reset), .motor_mode(motor_mode), .phase_current(phase_current),
    .group_switch_current_threshold(group_switch_current_threshold), .group_b_configured(group_b_configured),
    .group_select_input(group_select_input), .thermal_lockout_input(thermal_lockout_input),
    .remote_thermal_inhibit_order(remote_thermal_inhibit_order), .starts_per_hour_inhibit(starts_per_hour_inhibit),
    .ambient_valid(ambient_valid), .thermal_alarm(thermal_alarm), .thermal_trip(thermal_trip),
    .start_inhibit(start_inhibit), .heat_rise(heat_rise), .saved_heat(saved_heat), .active_group(active_group)
);
`default_nettype wire

/* tos_supervisor_test.sv */
`timescale 1ns/10ps
`default_nettype none
module tos_supervisor_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        motor_mode = 1'b1;
    logic [15:0] phase_current = 16'h0000;
    logic [15:0] group_switch_current_threshold = 16'h0300;
    logic        group_b_configured = 1'b1;
    logic [8:0]  start_heat_allowance = 9'h014;
    logic        setting_write = 1'b0;
    logic        setting_group = 1'b0;
    logic [2:0]  setting_field = 3'h0;
    logic [15:0] setting_data = 16'h0000;
    logic        group_select_input = 1'b0;
    logic        thermal_lockout_input = 1'b0;
    logic        send_inhibit = 1'b0;
    logic        send_enable = 1'b0;
    logic        close_request = 1'b1;
    logic        starts_per_hour_inhibit = 1'b0;
    logic [23:0] restore_heat = 24'h000000;
    logic        restore_valid = 1'b0;
    logic [1:0]  negseq_factor_sel = 2'h0;
    logic        ambient_valid = 1'b0;
    wire logic   thermal_alarm, thermal_trip, start_inhibit, active_group, breaker_closed;
    wire logic   remote_thermal_inhibit_order, remote_thermal_enable_order;
    wire logic [23:0] heat_rise, saved_heat;
    wire logic [15:0] time_to_trip, time_to_restart;
    int          failures = 0;
    int          n_checks = 0;
    // Group a: alarm 90, trip 110, offset 0, tc 1 and 5; group b trip 400 clamps to 300
    logic [15:0] table_a [5] = '{16'h005a, 16'h006e, 16'h0000, 16'h0001, 16'h0005};
    logic [15:0] table_b [5] = '{16'h00fa, 16'h0190, 16'h0000, 16'h0001, 16'h0005};

    always #12.5 clk = ~clk;

    tos_supervisor #(.BASE_TICK_CYCLES(4)) tos_supervisor_inst
    (
        .clk(clk), .reset(reset), .motor_mode(motor_mode), .phase_current(phase_current),
        .negseq_current(16'h0000), .negseq_factor_sel(negseq_factor_sel), .ambient_temp(8'h14),
        .ambient_valid(ambient_valid),
        .max_equipment_temp(8'h9b), .group_switch_current_threshold(group_switch_current_threshold),
        .group_b_configured(group_b_configured), .start_heat_allowance(start_heat_allowance),
        .setting_write(setting_write), .setting_group(setting_group), .setting_field(setting_field),
        .setting_data(setting_data), .group_select_input(group_select_input),
        .thermal_lockout_input(thermal_lockout_input), .remote_thermal_inhibit_order(remote_thermal_inhibit_order),
        .remote_thermal_enable_order(remote_thermal_enable_order), .starts_per_hour_inhibit(starts_per_hour_inhibit),
        .restore_heat(restore_heat), .restore_valid(restore_valid), .thermal_alarm(thermal_alarm),
        .thermal_trip(thermal_trip), .start_inhibit(start_inhibit), .heat_rise(heat_rise), .saved_heat(saved_heat),
        .time_to_trip(time_to_trip), .time_to_restart(time_to_restart), .active_group(active_group)
    );
    tos_remote_model tos_remote_model_inst
    (
        .clk(clk), .send_inhibit(send_inhibit), .send_enable(send_enable), .close_request(close_request),
        .start_inhibit(start_inhibit), .remote_thermal_inhibit_order(remote_thermal_inhibit_order),
        .remote_thermal_enable_order(remote_thermal_enable_order), .breaker_closed(breaker_closed)
    );

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task check(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_true(input string name, input logic cond);
        check(name, 24'h000001, {23'h000000, cond});
    endtask
    function logic pick(input int sel);
        case (sel)
            0: pick = thermal_alarm;
            1: pick = thermal_trip;
            default: pick = start_inhibit;
        endcase
    endfunction
    // Bounded wait, also reports how long it took
    task wait_level(input int sel, input logic val, input int limit, output int took);
        took = 0;
        while (pick(sel) !== val && took < limit)
        begin
            step(1);
            took++;
        end
        check_true("wait_level", pick(sel) === val);
    endtask
    // Strobe stays up across the ten writes, dropped once at the end
    task write_groups;
        for (int i = 0; i < 10; i++)
        begin
            setting_write = 1'b1;
            setting_group = (i >= 5);
            setting_field = 3'(i % 5);
            setting_data = (i >= 5) ? table_b[i % 5] : table_a[i % 5];
            step(1);
        end
        setting_write = 1'b0;
    endtask
    task give_order(input logic inhibit);
        send_inhibit = inhibit;
        send_enable = !inhibit;
        step(1);
        send_inhibit = 1'b0;
        send_enable = 1'b0;
        step(3);
    endtask
    task final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #(25 * 80000);
        failures++;
        final_report;
    end

    initial
    begin
        logic [23:0] h;
        int          took;
        step(4);
        check("time_to_trip_reset", 24'h00ffff, {8'h00, time_to_trip});
        check("heat_reset", 24'h000000, heat_rise);
        reset = 1'b0;
        write_groups;
        phase_current = 16'h0200;
        wait_level(0, 1'b1, 3000, took);
        check_true("alarm_heat", heat_rise > 24'h00e666);
        check("trip_at_alarm", 24'h000000, {23'h0, thermal_trip});
        wait_level(1, 1'b1, 3000, took);
        check_true("trip_heat", heat_rise > 24'h011999);
        step(2);
        check_true("saved_heat", saved_heat > heat_rise);
        check("start_inhibit", 24'h000001, {23'h0, start_inhibit});
        check("breaker_closed", 24'h000000, {23'h0, breaker_closed});
        check_true("time_to_restart", time_to_restart != 16'h0000);
        give_order(1'b1);
        check("trip_inhibited", 24'h000000, {23'h0, thermal_trip});
        give_order(1'b0);
        check("trip_enabled", 24'h000001, {23'h0, thermal_trip});
        thermal_lockout_input = 1'b1;
        step(6);
        check("trip_input_lock", 24'h000000, {23'h0, thermal_trip});
        give_order(1'b0);
        check("trip_lock_kept", 24'h000000, {23'h0, thermal_trip});
        thermal_lockout_input = 1'b0;
        step(6);
        check("trip_unlocked", 24'h000001, {23'h0, thermal_trip});
        h = heat_rise;
        group_switch_current_threshold = 16'h0180;
        step(8);
        check("group_by_current", 24'h000001, {23'h0, active_group});
        check_true("heat_kept", heat_rise >= h && heat_rise - h < 24'h000400);
        check("trip_group_b", 24'h000000, {23'h0, thermal_trip});
        group_switch_current_threshold = 16'h0300;
        group_select_input = 1'b1;
        step(8);
        check("group_by_input", 24'h000001, {23'h0, active_group});
        group_select_input = 1'b0;
        step(8);
        check("group_back_a", 24'h000000, {23'h0, active_group});
        check("trip_group_a", 24'h000001, {23'h0, thermal_trip});
        phase_current = 16'h0019;
        wait_level(2, 1'b0, 30000, took);
        check_true("cooling_slow", took > 2000);
        check_true("restart_heat", heat_rise <= 24'h00e666);
        step(2);
        check("saved_cleared", 24'h000000, saved_heat);
        check("trip_cool", 24'h000000, {23'h0, thermal_trip | thermal_alarm});
        check("breaker_reclosed", 24'h000001, {23'h0, breaker_closed});
        starts_per_hour_inhibit = 1'b1;
        step(2);
        check("starts_inhibit", 24'h000001, {23'h0, start_inhibit});
        starts_per_hour_inhibit = 1'b0;
        motor_mode = 1'b0;
        group_select_input = 1'b1;
        step(7);
        check("xfmr_group_b", 24'h000001, {23'h0, active_group});
        group_b_configured = 1'b0;
        step(2);
        check("unset_group_b", 24'h000000, {23'h0, active_group});
        group_select_input = 1'b0;
        step(7);
        check("xfmr_group_a", 24'h000000, {23'h0, active_group | start_inhibit});
        motor_mode = 1'b1;
        restore_heat = 24'h012000;
        restore_valid = 1'b1;
        reset = 1'b1;
        step(4);
        reset = 1'b0;
        step(2);
        check_true("heat_restored", heat_rise <= 24'h012000 && heat_rise > 24'h011e00);
        write_groups;
        step(4);
        check("trip_restored", 24'h000001, {23'h0, thermal_trip});
        final_report;
    end
endmodule // tos_supervisor_test
`default_nettype wire
